// ==== verilog/move_decoder_defs.svh ====
// Constants for the move-based instruction decoder core.
// Assumes inclusion by bare name from every file that needs it.
`ifndef MOVE_DECODER_DEFS_SVH
`define MOVE_DECODER_DEFS_SVH

// ----------------------------------------------------------------
// Instruction word fields
// ----------------------------------------------------------------
`define INSTR_W 16
`define FMT_BIT 15
`define SRC_MSB 7
`define SRC_LSB 0
`define SRC_MOD_MSB 3
`define SRC_IDX_MSB 7
`define SRC_IDX_LSB 4
`define DST_MOD_MSB 11
`define DST_MOD_LSB 8
`define DST_SUB_MSB 14
`define DST_SUB_LSB 12
`define FMT_IMMEDIATE 1'h0

// ----------------------------------------------------------------
// Internal module codes and register indices
// ----------------------------------------------------------------
`define MOD_PC 4'h0
`define MOD_ACC 4'h1
`define MOD_MEM 4'h2
`define MOD_DP 4'h3
`define MOD_PREFIX 4'hb
`define MOD_STK 4'hd
`define MOD_CTRL 4'he
`define IDX_ACC_LOAD 5'h00
`define IDX_ACC_ADD 5'h01
`define IDX_ACC_SUB 5'h02
`define IDX_ACC_AND 5'h03
`define IDX_ACC_OR 5'h04
`define IDX_ACC_XOR 5'h05
`define IDX_STK_TOP 5'h00
`define IDX_STK_PTR 5'h01
`define IDX_CTRL_STEP 5'h00
`define IDX_CTRL_ORG 5'h01

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PC_RST 16'h8000
`define ACC_RST 16'h0000
`define SP_RST 4'hf
`define STEP_RST 6'h00
`define ORG_RST 1'h0

// ----------------------------------------------------------------
// Unified memory map boundaries
// ----------------------------------------------------------------
`define UROM_BASE 16'h8000
`define UROM_LAST 16'h8fff

`endif

// ==== verilog/move_decoder_pkg.sv ====
// Types shared by the move-based instruction decoder core.
// Assumes the constants header is included alongside.
package move_decoder_pkg;

  typedef logic [15:0] word_t;
  typedef logic [3:0] mod_id_t;

  typedef enum logic [1:0] {
    SPACE_DATA = 2'h0,
    SPACE_CODE = 2'h1,
    SPACE_UROM = 2'h2
  } mem_space_t;

endpackage : move_decoder_pkg

// ==== verilog/return_stack.sv ====
// Stack storage with registered read data and write forwarding.
// Assumes one clock, enable gating from the core and no reset on the array.
`timescale 1ns/10ps
module return_stack #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 16,
  parameter int AW = 4
) (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [WIDTH-1:0] wdata_in,
  input wire logic [AW-1:0] raddr_in,
  output logic [WIDTH-1:0] rdata_out
);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [WIDTH-1:0] rdata_q;
  wire fwd = we_in && (waddr_in == raddr_in);

  always_ff @(posedge core_clk_in) begin
    if (ce_in && we_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  // Read port tracks the entry the pointer will address next
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      rdata_q <= '0;
    end else if (ce_in) begin
      rdata_q <= fwd ? wdata_in : mem[raddr_in];
    end
  end

  assign rdata_out = rdata_q;

endmodule : return_stack

// ==== verilog/move_instruction_decoder.sv ====
// Single-cycle move-instruction decoder and execution control.
// Assumes program memory returns the word at pc_out in the same cycle,
// data memory reads asynchronously, peripherals answer reads combinationally.
//
// Contract
// - Only fixed sixteen-bit instruction words accepted
// - Top bit picks literal or register source
// - Source taken from low eight bits
// - Source low nibble module, high nibble index
// - Bits eight-fourteen: destination module and subindex
// - Prefix bits extend destination to upper registers
// - Prefix write costs exactly one extra cycle
// - Fetch and execute in one clock cycle
// - Designated register accesses trigger side effects
// - ALU combines accumulator with any register
// - Sixteen-entry hardware return-address stack
// - Three data pointers auto-step after access
// - Harvard default, optional unified memory map
// - Pointer resets to top; push pre-increments
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`include "move_decoder_defs.svh"
module move_instruction_decoder #(
  parameter int DP_COUNT = 3,
  parameter int STACK_DEPTH = 16,
  parameter int STACK_AW = 4
) (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic [15:0] instr_in,
  output move_decoder_pkg::word_t pc_out,
  output move_decoder_pkg::word_t acc_out,
  output logic [STACK_AW-1:0] sp_out,
  output logic prefix_active_out,
  output logic unified_out,
  output move_decoder_pkg::word_t dmem_raddr_out,
  output logic dmem_re_out,
  input wire logic [15:0] dmem_rdata_in,
  output move_decoder_pkg::mem_space_t dmem_rspace_out,
  output move_decoder_pkg::word_t dmem_waddr_out,
  output move_decoder_pkg::word_t dmem_wdata_out,
  output logic dmem_we_out,
  output move_decoder_pkg::mem_space_t dmem_wspace_out,
  output logic periph_rd_out,
  output move_decoder_pkg::mod_id_t periph_src_mod_out,
  output logic [3:0] periph_src_idx_out,
  input wire logic [15:0] periph_rdata_in,
  output logic periph_wr_out,
  output move_decoder_pkg::mod_id_t periph_dst_mod_out,
  output logic [4:0] periph_dst_idx_out,
  output move_decoder_pkg::word_t periph_wdata_out
);
  import move_decoder_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  word_t pc_q;
  word_t pc_d;
  word_t acc_q;
  word_t acc_d;
  logic [STACK_AW-1:0] sp_q;
  logic [STACK_AW-1:0] sp_d;
  logic [1:0] prefix_q;
  logic [1:0] prefix_d;
  logic prefix_valid_q;
  logic prefix_valid_d;
  logic [2*DP_COUNT-1:0] step_q;
  logic [2*DP_COUNT-1:0] step_d;
  logic org_q;
  logic org_d;
  logic [16*DP_COUNT-1:0] dp_flat;

  // ----------------------------------------------------------------
  // Field split
  // ----------------------------------------------------------------
  wire [15:0] iw = instr_in;
  wire src_is_reg = (iw[`FMT_BIT] != `FMT_IMMEDIATE);
  wire [7:0] src_field = iw[`SRC_MSB:`SRC_LSB];
  wire [3:0] src_mod = src_field[`SRC_MOD_MSB:0];
  wire [3:0] src_idx = src_field[`SRC_IDX_MSB:`SRC_IDX_LSB];
  wire [4:0] src_idx5 = {1'h0, src_idx};
  wire [3:0] dst_mod = iw[`DST_MOD_MSB:`DST_MOD_LSB];
  wire [2:0] dst_sub = iw[`DST_SUB_MSB:`DST_SUB_LSB];
  wire [1:0] dst_ext = prefix_valid_q ? prefix_q : 2'h0;
  wire [4:0] dst_idx = {dst_ext, dst_sub};

  // ----------------------------------------------------------------
  // Source decode
  // ----------------------------------------------------------------
  wire s_pc = src_is_reg && (src_mod == `MOD_PC);
  wire s_acc = src_is_reg && (src_mod == `MOD_ACC);
  wire s_mem = src_is_reg && (src_mod == `MOD_MEM);
  wire s_dp = src_is_reg && (src_mod == `MOD_DP);
  wire s_prefix = src_is_reg && (src_mod == `MOD_PREFIX);
  wire s_stk = src_is_reg && (src_mod == `MOD_STK);
  wire s_ctl = src_is_reg && (src_mod == `MOD_CTRL);
  wire s_int = s_pc || s_acc || s_mem || s_dp || s_prefix || s_stk || s_ctl;
  wire s_ext = src_is_reg && !s_int;
  wire s_pop = s_stk && (src_idx5 == `IDX_STK_TOP);
  wire s_sp = s_stk && (src_idx5 == `IDX_STK_PTR);
  wire s_step = s_ctl && (src_idx5 == `IDX_CTRL_STEP);
  wire s_org = s_ctl && (src_idx5 == `IDX_CTRL_ORG);
  wire [1:0] s_dpsel = src_idx[1:0];

  // ----------------------------------------------------------------
  // Destination decode
  // ----------------------------------------------------------------
  wire d_pc = (dst_mod == `MOD_PC);
  wire d_acc = (dst_mod == `MOD_ACC);
  wire d_mem = (dst_mod == `MOD_MEM);
  wire d_dp = (dst_mod == `MOD_DP);
  wire d_prefix = (dst_mod == `MOD_PREFIX);
  wire d_stk = (dst_mod == `MOD_STK);
  wire d_ctl = (dst_mod == `MOD_CTRL);
  wire d_int = d_pc || d_acc || d_mem || d_dp || d_prefix || d_stk || d_ctl;
  wire d_push = d_stk && (dst_idx == `IDX_STK_TOP);
  wire d_sp = d_stk && (dst_idx == `IDX_STK_PTR);
  wire d_step = d_ctl && (dst_idx == `IDX_CTRL_STEP);
  wire d_org = d_ctl && (dst_idx == `IDX_CTRL_ORG);
  wire [1:0] d_dpsel = dst_idx[1:0];

  // ----------------------------------------------------------------
  // Source value
  // ----------------------------------------------------------------
  word_t stk_top;
  word_t dp_src;
  word_t dp_dst;
  word_t src_reg_val;
  word_t src_val;

  assign dp_src = (s_dpsel < DP_COUNT) ? dp_flat[16*s_dpsel +: 16] : 16'h0000;
  assign dp_dst = (d_dpsel < DP_COUNT) ? dp_flat[16*d_dpsel +: 16] : 16'h0000;

  // Any register may feed the transfer, the ALU included
  always_comb begin
    src_reg_val = periph_rdata_in;
    if (s_pc) begin
      src_reg_val = pc_q;
    end else if (s_acc) begin
      src_reg_val = acc_q;
    end else if (s_mem) begin
      src_reg_val = dmem_rdata_in;
    end else if (s_dp) begin
      src_reg_val = dp_src;
    end else if (s_prefix) begin
      src_reg_val = {14'h0000, prefix_q};
    end else if (s_pop) begin
      src_reg_val = stk_top;
    end else if (s_sp) begin
      src_reg_val = {{(16-STACK_AW){1'h0}}, sp_q};
    end else if (s_step) begin
      src_reg_val = {{(16-2*DP_COUNT){1'h0}}, step_q};
    end else if (s_org) begin
      src_reg_val = {15'h0000, org_q};
    end else if (s_int) begin
      src_reg_val = 16'h0000;
    end
  end

  assign src_val = src_is_reg ? src_reg_val : {8'h00, src_field};

  // ----------------------------------------------------------------
  // Accumulator and ALU
  // ----------------------------------------------------------------
  always_comb begin
    acc_d = acc_q;
    if (d_acc) begin
      case (dst_idx)
        `IDX_ACC_LOAD: acc_d = src_val;
        `IDX_ACC_ADD: acc_d = acc_q + src_val;
        `IDX_ACC_SUB: acc_d = acc_q - src_val;
        `IDX_ACC_AND: acc_d = acc_q & src_val;
        `IDX_ACC_OR: acc_d = acc_q | src_val;
        `IDX_ACC_XOR: acc_d = acc_q ^ src_val;
        default: acc_d = acc_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------
  // A write to the counter is a jump; otherwise step to the next word
  assign pc_d = (d_pc && (dst_idx == 5'h00)) ? src_val : pc_q + 16'h0001;

  // ----------------------------------------------------------------
  // Prefix
  // ----------------------------------------------------------------
  // The prefix instruction is its own cycle; the value lives one instruction
  assign prefix_d = d_prefix ? src_val[1:0] : 2'h0;
  assign prefix_valid_d = d_prefix;

  // ----------------------------------------------------------------
  // Stack pointer
  // ----------------------------------------------------------------
  logic [STACK_AW-1:0] sp_popped;
  wire [STACK_AW-1:0] sp_one = {{(STACK_AW-1){1'h0}}, 1'h1};

  // Pop reads then decrements; push increments then stores
  assign sp_popped = s_pop ? sp_q - sp_one : sp_q;
  always_comb begin
    sp_d = sp_popped;
    if (d_sp) begin
      sp_d = src_val[STACK_AW-1:0];
    end else if (d_push) begin
      sp_d = sp_popped + sp_one;
    end
  end

  return_stack #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(16),
    .AW(STACK_AW)
  ) u_stack (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .we_in(d_push),
    .waddr_in(sp_d),
    .wdata_in(src_val),
    .raddr_in(sp_d),
    .rdata_out(stk_top)
  );

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  assign step_d = d_step ? src_val[2*DP_COUNT-1:0] : step_q;
  assign org_d = d_org ? src_val[0] : org_q;

  // ----------------------------------------------------------------
  // Data pointers
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < DP_COUNT; g++) begin : g_dp
      logic [15:0] dp_q;
      logic [15:0] dp_d;
      wire wr = d_dp && (d_dpsel == 2'(g));
      wire used = (s_mem && (s_dpsel == 2'(g))) || (d_mem && (d_dpsel == 2'(g)));
      wire en = step_q[2*g];
      wire down = step_q[2*g+1];
      // Explicit load wins over the automatic step
      assign dp_d = wr ? src_val :
                    (used && en) ? (down ? dp_q - 16'h0001 : dp_q + 16'h0001) :
                    dp_q;
      always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
          dp_q <= 16'h0000;
        end else if (ce_in) begin
          dp_q <= dp_d;
        end
      end
      assign dp_flat[16*g +: 16] = dp_q;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Memory space decode
  // ----------------------------------------------------------------
  function automatic mem_space_t space_of(input logic unified, input logic [15:0] a);
    mem_space_t s;
    s = SPACE_DATA;
    if (unified) begin
      if (a < `UROM_BASE) begin
        s = SPACE_CODE;
      end else if (a <= `UROM_LAST) begin
        s = SPACE_UROM;
      end
    end
    return s;
  endfunction : space_of

  assign dmem_raddr_out = dp_src;
  assign dmem_re_out = ce_in && s_mem;
  assign dmem_rspace_out = space_of(org_q, dp_src);
  assign dmem_waddr_out = dp_dst;
  assign dmem_wdata_out = src_val;
  assign dmem_we_out = ce_in && d_mem;
  assign dmem_wspace_out = space_of(org_q, dp_dst);

  // ----------------------------------------------------------------
  // Peripheral transfers
  // ----------------------------------------------------------------
  // Non-core modules see the access as a strobe with its side effects
  assign periph_rd_out = ce_in && s_ext;
  assign periph_src_mod_out = src_mod;
  assign periph_src_idx_out = src_idx;
  assign periph_wr_out = ce_in && !d_int;
  assign periph_dst_mod_out = dst_mod;
  assign periph_dst_idx_out = dst_idx;
  assign periph_wdata_out = src_val;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      pc_q <= `PC_RST;
      acc_q <= `ACC_RST;
    end else if (ce_in) begin
      pc_q <= pc_d;
      acc_q <= acc_d;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      sp_q <= STACK_AW'(`SP_RST);
      prefix_q <= 2'h0;
      prefix_valid_q <= 1'h0;
    end else if (ce_in) begin
      sp_q <= sp_d;
      prefix_q <= prefix_d;
      prefix_valid_q <= prefix_valid_d;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      step_q <= (2*DP_COUNT)'(`STEP_RST);
      org_q <= `ORG_RST;
    end else if (ce_in) begin
      step_q <= step_d;
      org_q <= org_d;
    end
  end

  // ----------------------------------------------------------------
  // Observation outputs
  // ----------------------------------------------------------------
  assign pc_out = pc_q;
  assign acc_out = acc_q;
  assign sp_out = sp_q;
  assign prefix_active_out = prefix_valid_q;
  assign unified_out = org_q;

endmodule : move_instruction_decoder

// ==== test/move_decoder_props.sv ====
// Concurrent checks on the ports of the move-instruction decoder.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/10ps
module move_decoder_props #(
  parameter int STACK_AW = 4
) (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic [15:0] instr_in,
  input wire move_decoder_pkg::word_t pc_out,
  input wire logic [STACK_AW-1:0] sp_out,
  input wire logic prefix_active_out,
  input wire logic unified_out,
  input wire logic dmem_re_out,
  input wire move_decoder_pkg::mem_space_t dmem_rspace_out,
  input wire logic periph_rd_out,
  input wire move_decoder_pkg::mod_id_t periph_src_mod_out,
  input wire logic [3:0] periph_src_idx_out,
  input wire logic periph_wr_out,
  input wire move_decoder_pkg::mod_id_t periph_dst_mod_out,
  input wire logic [4:0] periph_dst_idx_out
);
  import move_decoder_pkg::*;
  wire go = ce_in & ~srst_in;
  wire push = instr_in[14:8] == 7'h0d && !prefix_active_out;
  wire pop = instr_in[15] && instr_in[7:0] == 8'h0d;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  a_pc_steps: assert property (go && instr_in[11:8] != 4'h0 |=> pc_out == $past(pc_out) + 16'h1)
    else $error("pc did not advance by one");
  a_hold_frozen: assert property (!ce_in |=> $stable(pc_out) && $stable(sp_out))
    else $error("state moved while disabled");
  a_literal_src: assert property (!instr_in[15] |-> !periph_rd_out && !dmem_re_out)
    else $error("literal source caused a read");
  a_src_split: assert property (periph_rd_out |->
    periph_src_mod_out == instr_in[3:0] && periph_src_idx_out == instr_in[7:4])
    else $error("source fields wrong");
  a_dst_split: assert property (periph_wr_out |->
    periph_dst_mod_out == instr_in[11:8] && periph_dst_idx_out[2:0] == instr_in[14:12])
    else $error("destination fields wrong");
  a_prefix_arms: assert property (go && instr_in[14:8] == 7'h0b && !prefix_active_out
    |=> prefix_active_out)
    else $error("prefix write not taken");
  a_prefix_once: assert property (go && prefix_active_out && instr_in[11:8] != 4'hb
    |=> !prefix_active_out)
    else $error("prefix outlived its instruction");
  a_plain_index: assert property (periph_wr_out && !prefix_active_out
    |-> periph_dst_idx_out[4:3] == 2'b00)
    else $error("unprefixed index extended");
  a_push_sp: assert property (go && push && !pop |=> sp_out == $past(sp_out) + 1'b1)
    else $error("push did not raise pointer");
  a_pop_sp: assert property (go && pop && instr_in[11:8] != 4'hd
    |=> sp_out == $past(sp_out) - 1'b1)
    else $error("pop did not lower pointer");
  a_harvard_space: assert property (dmem_re_out && !unified_out
    |-> dmem_rspace_out == SPACE_DATA)
    else $error("read left data space");
endmodule : move_decoder_props

bind move_instruction_decoder move_decoder_props #(.STACK_AW(STACK_AW)) props_inst (
  .core_clk_in, .srst_in, .ce_in, .instr_in, .pc_out, .sp_out, .prefix_active_out,
  .unified_out, .dmem_re_out, .dmem_rspace_out, .periph_rd_out, .periph_src_mod_out,
  .periph_src_idx_out, .periph_wr_out, .periph_dst_mod_out, .periph_dst_idx_out
);

// ==== test/prog_mem_model.sv ====
// Program memory model: one sixteen-bit word per address, read without a clock.
// Assumes the bench stores each word before the core fetches it.
`timescale 1ns/10ps
module prog_mem_model (
  input wire logic [15:0] addr_in,
  output logic [15:0] word_out
);
  logic [15:0] mem [0:65535];
  // Unwritten words decode as harmless peripheral moves
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 16'hffff;
    end
  end
  assign word_out = mem[addr_in];
endmodule : prog_mem_model

// ==== test/test_move_instruction_decoder.sv ====
// Self-checking bench for the move-instruction decoder.
// Assumes the program memory model answers at pc_out within the cycle.
`timescale 1ns/10ps
module test_move_instruction_decoder;
  import move_decoder_pkg::*;
  logic core_clk_in, srst_in, ce_in;
  logic [15:0] instr_in, dmem_rdata_in, periph_rdata_in, epc, eacc, lit, fix;
  word_t pc_out, acc_out, dmem_raddr_out, dmem_waddr_out, dmem_wdata_out, periph_wdata_out;
  logic [3:0] sp_out, periph_src_idx_out;
  mod_id_t periph_src_mod_out, periph_dst_mod_out;
  logic [4:0] periph_dst_idx_out;
  logic prefix_active_out, unified_out, dmem_re_out, dmem_we_out, periph_rd_out;
  logic periph_wr_out, fix_en;
  mem_space_t dmem_rspace_out, dmem_wspace_out;
  int errors, comparisons;
  integer seed;

  move_instruction_decoder move_instruction_decoder_inst (
    .core_clk_in, .srst_in, .ce_in, .instr_in, .pc_out, .acc_out, .sp_out,
    .prefix_active_out, .unified_out, .dmem_raddr_out, .dmem_re_out, .dmem_rdata_in,
    .dmem_rspace_out, .dmem_waddr_out, .dmem_wdata_out, .dmem_we_out, .dmem_wspace_out,
    .periph_rd_out, .periph_src_mod_out, .periph_src_idx_out, .periph_rdata_in,
    .periph_wr_out, .periph_dst_mod_out, .periph_dst_idx_out, .periph_wdata_out
  );
  prog_mem_model prog_mem_model_inst (.addr_in(pc_out), .word_out(instr_in));

  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end

  always @(posedge core_clk_in) begin
    dmem_rdata_in <= $random(seed);
    periph_rdata_in <= fix_en ? fix : $random(seed);
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  function automatic logic [15:0] alu(input int op, input logic [15:0] a, input logic [15:0] b);
    case (op)
      0: return b;
      1: return a + b;
      2: return a - b;
      3: return a & b;
      4: return a | b;
      default: return a ^ b;
    endcase
  endfunction : alu

  // Store the word at the expected pc and let it settle
  task automatic put(input logic [15:0] w);
    prog_mem_model_inst.mem[epc] = w;
    #1;
  endtask : put

  task automatic done;
    @(posedge core_clk_in);
    #1;
    epc = epc + 16'h1;
    check(pc_out, epc);
  endtask : done

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'hc435;
    errors = 0;
    comparisons = 0;
    fix_en = 1'b0;
    fix = 16'h0000;
    srst_in = 1'b1;
    ce_in = 1'b1;
    dmem_rdata_in = 16'h0000;
    periph_rdata_in = 16'h0000;
    epc = 16'h8000;
    eacc = 16'h0000;
    repeat (2) @(posedge core_clk_in);
    srst_in <= 1'b0;
    #1;
    check(pc_out, epc);
    check(sp_out, 4'hf);
    check({prefix_active_out, unified_out}, 2'b00);
    for (int n = 0; n < 18; n++) begin
      lit = (n == 7) ? 16'h00ff : {8'h00, 8'($random(seed))};
      put({1'b0, 3'(n % 6), 4'h1, lit[7:0]});
      eacc = alu(n % 6, eacc, lit);
      done;
      check(acc_out, eacc);
    end
    put(16'h8135);
    check({periph_rd_out, periph_src_mod_out, periph_src_idx_out}, 9'h153);
    eacc = periph_rdata_in;
    done;
    check(acc_out, eacc);
    put(16'h56a5);
    check({periph_wr_out, periph_dst_mod_out, periph_dst_idx_out}, 10'h2c5);
    check(periph_wdata_out, 16'h00a5);
    done;
    put(16'h0b02);
    check(periph_wr_out, 1'b0);
    done;
    check(prefix_active_out, 1'b1);
    put(16'h36c3);
    check({periph_wr_out, periph_dst_idx_out}, 6'h33);
    done;
    put(16'h36c3);
    check({prefix_active_out, periph_dst_idx_out}, 6'h03);
    done;
    put(16'h0b01);
    done;
    put(16'h0b03);
    done;
    put(16'h36c4);
    check(periph_dst_idx_out, 5'h1b);
    done;
    for (int i = 0; i < 2; i++) begin
      put({8'h0d, 8'(5 + 2 * i)});
      done;
      check(sp_out, 4'(i));
    end
    put(16'h810d);
    done;
    check({acc_out, sp_out}, 20'h00070);
    put(16'h810d);
    done;
    check({acc_out, sp_out}, 20'h0005f);
    put(16'h0340);
    done;
    put(16'h0e0d);
    done;
    put(16'h025a);
    check({dmem_we_out, dmem_waddr_out, dmem_wdata_out}, 33'h10040005a);
    check(dmem_wspace_out, SPACE_DATA);
    done;
    put(16'h8102);
    check({dmem_re_out, dmem_raddr_out}, 17'h10041);
    eacc = dmem_rdata_in;
    done;
    check(acc_out, eacc);
    put(16'h1310);
    done;
    for (int n = 0; n < 2; n++) begin
      put(16'h8112);
      check(dmem_raddr_out, 16'h0010 - n);
      eacc = dmem_rdata_in;
      done;
      check(acc_out, eacc);
    end
    fix = 16'h8010;
    fix_en = 1'b1;
    put(16'h1e01);
    done;
    check(unified_out, 1'b1);
    put(16'h8102);
    check(dmem_rspace_out, SPACE_CODE);
    eacc = dmem_rdata_in;
    done;
    put(16'ha305);
    done;
    put(16'h8122);
    check({dmem_raddr_out, dmem_rspace_out}, {16'h8010, SPACE_UROM});
    eacc = dmem_rdata_in;
    done;
    check(acc_out, eacc);
    fix_en = 1'b0;
    ce_in <= 1'b0;
    put(16'h56a5);
    check({periph_wr_out, periph_rd_out}, 2'b00);
    @(posedge core_clk_in);
    #1;
    check({pc_out, acc_out}, {epc, eacc});
    ce_in <= 1'b1;
    put(16'h0020);
    @(posedge core_clk_in);
    #1;
    epc = 16'h0020;
    check(pc_out, epc);
    put(16'h0133);
    done;
    check(acc_out, 16'h0033);
    end_sim;
  end

  initial begin
    #100000;
    errors++;
    end_sim;
  end
endmodule : test_move_instruction_decoder
